/* verilog/watchdog_timer16_pkg.sv */
// constants for the 16-bit watchdog timer
package watchdog_timer16_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte addresses
    localparam logic [31:0] RELOAD_ADDR = 32'hffff0360;
    localparam logic [31:0] COUNT_ADDR = 32'hffff0364;
    localparam logic [31:0] CONTROL_ADDR = 32'hffff0368;
    localparam logic [31:0] SERVICE_ADDR = 32'hffff036c;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [15:0] RELOAD_RESET = 16'h0040;
    localparam logic [15:0] COUNT_RESET = 16'h0040;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // control field positions
    localparam int CTL_STOP_PD = 0;
    localparam int CTL_IRQ_SEL = 1;
    localparam int CTL_PRESC_LO = 2;
    localparam int CTL_PRESC_HI = 3;
    localparam int CTL_WDOG = 5;
    localparam int CTL_PERIODIC = 6;
    localparam int CTL_ENABLE = 7;
    localparam int CTL_COUNT_UP = 8;
    localparam logic [15:0] CONTROL_MASK = 16'h01ef;

    ////////////////////////////////////////////////////////////////////////////
    // prescaler encodings and terminal counts
    typedef enum logic [1:0] {
        PRESC_DIV1 = 2'b00,
        PRESC_DIV16 = 2'b01,
        PRESC_DIV256 = 2'b10,
        PRESC_RSVD = 2'b11
    } presc_sel_t;
    localparam logic [7:0] PRESC_LAST_DIV1 = 8'h00;
    localparam logic [7:0] PRESC_LAST_DIV16 = 8'h0f;
    localparam logic [7:0] PRESC_LAST_DIV256 = 8'hff;

    ////////////////////////////////////////////////////////////////////////////
    // timing figures
    localparam int LP_OSC_HZ = 32768;
    localparam int PCLK_HZ = 125000000;
    localparam int MAX_TIMEOUT_S = 512;
    localparam int MAX_TIMEOUT_TICKS = MAX_TIMEOUT_S * LP_OSC_HZ / 256;
    localparam int MIN_TIMEOUT_MS = 30;
    localparam int MIN_TIMEOUT_TICKS = (MIN_TIMEOUT_MS * LP_OSC_HZ + 999) / 1000;
    localparam logic [15:0] ALL_ONES = 16'hffff;
    localparam logic [15:0] ALL_ZERO = 16'h0000;

endpackage

/* verilog/watchdog_timer16.sv */
// 16-bit timer with normal and watchdog modes behind an apb slave
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps

// Behaviour
// - normal mode ticks from 32.768 kHz oscillator via divide 1, 16 or 256
// - normal mode overflow reloads counter from reload register when bit 6 is set, else the counter wraps
// - setting control bit 5 enters watchdog mode
// - watchdog mode decrements from reload value down to zero
// - divide 256 with all-ones reload gives a 512 second timeout
// - reaching zero in watchdog mode gives reset or interrupt per bit 1
// - service write before zero reloads counter and restarts the timeout
// - watchdog mode locks reload and control until power-on reset
// - resets other than power-on leave mode and counting untouched
// - counter halts while debug holds the core, resumes on release
// - counter runs in power-down unless control bit 0 is set
// - reload and count hold 16-bit unsigned values, count is read-only
// - normal mode service write clears the pending interrupt
// - prescaler bits 3:2 encode 00 /1, 01 /16, 10 /256, 11 reserved
// - bit 1 set gives interrupt at zero, clear gives reset
// - bit 7 enables the timer, bit 6 periodic when set else free-running
// - bit 8 makes the normal mode counter count up when set, down when clear
module watchdog_timer16 (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lp_osc_clk,
    input wire logic debug_halt,
    input wire logic periph_powerdown,
    output logic wdt_reset_req,
    output logic timer_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // prescaler terminal count
    function automatic logic [7:0] presc_last(input logic [1:0] sel);
        logic [7:0] r;
        r = watchdog_timer16_pkg::PRESC_LAST_DIV1;
        if (sel == watchdog_timer16_pkg::PRESC_DIV16) begin
            r = watchdog_timer16_pkg::PRESC_LAST_DIV16;
        end else if (sel == watchdog_timer16_pkg::PRESC_DIV256) begin
            r = watchdog_timer16_pkg::PRESC_LAST_DIV256;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [15:0] watchdog_reload;
    logic [15:0] watchdog_count;
    logic [15:0] watchdog_control;
    logic [7:0] presc_cnt;
    logic [2:0] osc_sync;
    logic [1:0] halt_sync;
    logic [1:0] pd_sync;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    wire access = psel && penable && !pready;
    wire done = psel && penable && pready;
    wire hit_reload = (paddr == watchdog_timer16_pkg::RELOAD_ADDR);
    wire hit_count = (paddr == watchdog_timer16_pkg::COUNT_ADDR);
    wire hit_control = (paddr == watchdog_timer16_pkg::CONTROL_ADDR);
    wire hit_service = (paddr == watchdog_timer16_pkg::SERVICE_ADDR);
    wire hit_any = hit_reload || hit_count || hit_control || hit_service;
    wire wr_done = done && pwrite;

    ////////////////////////////////////////////////////////////////////////////
    // control fields
    wire wdog_mode = watchdog_control[watchdog_timer16_pkg::CTL_WDOG];
    wire locked = wdog_mode;
    wire irq_sel = watchdog_control[watchdog_timer16_pkg::CTL_IRQ_SEL];
    wire stop_in_powerdown = watchdog_control[watchdog_timer16_pkg::CTL_STOP_PD];
    wire periodic = watchdog_control[watchdog_timer16_pkg::CTL_PERIODIC];
    wire enable = watchdog_control[watchdog_timer16_pkg::CTL_ENABLE];
    wire count_up = watchdog_control[watchdog_timer16_pkg::CTL_COUNT_UP];
    wire [1:0] presc_sel = watchdog_control[watchdog_timer16_pkg::CTL_PRESC_HI:
                                            watchdog_timer16_pkg::CTL_PRESC_LO];

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    wire wr_reload = wr_done && hit_reload && !locked;
    wire wr_control = wr_done && hit_control && !locked;
    wire wr_service = wr_done && hit_service;
    wire [15:0] next_control = pwdata[15:0] & watchdog_timer16_pkg::CONTROL_MASK;

    ////////////////////////////////////////////////////////////////////////////
    // tick generation
    wire osc_rise = osc_sync[1] && !osc_sync[2];
    wire halted = halt_sync[1] || (pd_sync[1] && stop_in_powerdown);
    wire running = (enable || wdog_mode) && !halted;
    wire presc_wrap = (presc_cnt == presc_last(presc_sel));
    wire tick = running && osc_rise && presc_wrap;
    wire [7:0] next_presc = (presc_wrap || wr_control) ? 8'h00 : presc_cnt + 8'h01;

    ////////////////////////////////////////////////////////////////////////////
    // counter next value
    wire at_top = (watchdog_count == watchdog_timer16_pkg::ALL_ONES);
    wire at_zero = (watchdog_count == watchdog_timer16_pkg::ALL_ZERO);
    wire at_one = (watchdog_count == 16'h0001);
    wire norm_over = count_up ? at_top : at_zero;
    wire [15:0] norm_step = count_up ? watchdog_count + 16'h0001 : watchdog_count - 16'h0001;
    wire [15:0] norm_next = (norm_over && periodic) ? watchdog_reload : norm_step;
    wire [15:0] wdog_next = at_zero ? watchdog_reload : watchdog_count - 16'h0001;
    wire wdog_expire = tick && wdog_mode && at_one;
    wire norm_event = tick && !wdog_mode && norm_over;
    wire [15:0] next_count = wdog_mode ? wdog_next : norm_next;

    ////////////////////////////////////////////////////////////////////////////
    // read data
    wire [15:0] rd_word = hit_reload ? watchdog_reload :
                          hit_count ? watchdog_count :
                          hit_control ? watchdog_control : 16'h0000;
    wire [31:0] next_prdata = {16'h0000, rd_word};

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_sync <= 3'b000;
            halt_sync <= 2'b00;
            pd_sync <= 2'b00;
        end else if (clk_en) begin
            osc_sync <= {osc_sync[1:0], lp_osc_clk};
            halt_sync <= {halt_sync[0], debug_halt};
            pd_sync <= {pd_sync[0], periph_powerdown};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb answer, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (clk_en) begin
            pready <= access;
            pslverr <= access && !hit_any;
            if (access && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers, reset only by power-on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_reload <= watchdog_timer16_pkg::RELOAD_RESET;
            watchdog_control <= watchdog_timer16_pkg::CONTROL_RESET;
        end else if (clk_en) begin
            if (wr_reload) begin
                watchdog_reload <= pwdata[15:0];
            end
            if (wr_control) begin
                watchdog_control <= next_control;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // prescaler and counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_cnt <= 8'h00;
            watchdog_count <= watchdog_timer16_pkg::COUNT_RESET;
        end else if (clk_en) begin
            if ((running && osc_rise) || wr_control) begin
                presc_cnt <= next_presc;
            end
            if (wr_service && wdog_mode) begin
                watchdog_count <= watchdog_reload;
            end else if (tick) begin
                watchdog_count <= next_count;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // expiry outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_reset_req <= 1'b0;
            timer_irq <= 1'b0;
        end else if (clk_en) begin
            wdt_reset_req <= wdog_expire && !irq_sel && !(wr_service && wdog_mode);
            if ((wdog_expire && irq_sel && !wr_service) || norm_event) begin
                timer_irq <= 1'b1;
            end else if (wr_service) begin
                timer_irq <= 1'b0;
            end
        end
    end

endmodule

/* testbench/watchdog_timer16_props.sv */
// port checker for the watchdog timer
`timescale 1ns/100ps
module watchdog_timer16_props (
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [31:0] paddr, pwdata, prdata,
    input wire logic wdt_reset_req, timer_irq
);
    wire logic hit = (paddr[31:4] == 28'hffff036) && (paddr[1:0] == 2'b00);
    wire logic wr = psel && penable && pready && pwrite;
    wire logic rd = psel && penable && pready && !pwrite;
    logic [15:0] ctl;
    logic [15:0] rl;
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= 16'h0000;
            rl <= 16'h0040;
        end else if (wr && hit && !ctl[5]) begin
            if (paddr[3:2] == 2'h2)
                ctl <= pwdata[15:0] & 16'h01ef;
            if (paddr[3:2] == 2'h0)
                rl <= pwdata[15:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    error_map_a: assert property (pready && psel |-> pslverr == !hit)
        else $error("pslverr wrong");
    read_width_a: assert property (rd |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    control_lock_a: assert property (rd && hit && paddr[3:2] == 2'h2 |-> prdata[15:0] == ctl)
        else $error("control value wrong");
    reload_lock_a: assert property (rd && hit && paddr[3:2] == 2'h0 |-> prdata[15:0] == rl)
        else $error("reload value wrong");
    reset_select_a: assert property (wdt_reset_req |-> ctl[5] && !ctl[1])
        else $error("reset without reset select");
    irq_select_a: assert property ($rose(timer_irq) && ctl[5] |-> ctl[1])
        else $error("irq without irq select");
    irq_clear_a: assert property ($fell(timer_irq) |-> $past(wr && paddr[3:0] == 4'hc))
        else $error("irq cleared without service");
endmodule
bind watchdog_timer16 watchdog_timer16_props props_i (.*);

/* testbench/testbench.sv */
// self-checking bench for the watchdog timer
`timescale 1ns/100ps
module testbench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic lp_osc_clk = 0, debug_halt = 0, periph_powerdown = 0, clk_en = 1;
    logic [31:0] paddr = 0, pwdata = 0, prdata, r, a;
    logic pready, pslverr, wdt_reset_req, timer_irq;
    int failures = 0, checked = 0, seed = 88, n, p;
    realtime t0;
    localparam int TMIN = watchdog_timer16_pkg::MIN_TIMEOUT_TICKS;
    watchdog_timer16 uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lp_osc_clk(lp_osc_clk), .debug_halt(debug_halt),
        .periph_powerdown(periph_powerdown), .wdt_reset_req(wdt_reset_req),
        .timer_irq(timer_irq));
    always #4 pclk = ~pclk;
    always begin
        repeat (4) @(posedge pclk);
        lp_osc_clk <= ~lp_osc_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [2:0] i, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= watchdog_timer16_pkg::RELOAD_ADDR + {27'h0, i, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wait_for(input logic rst, input int lim);
        for (n = 0; n < lim && (rst ? wdt_reset_req : timer_irq) !== 1'b1; n++)
            @(posedge pclk);
        chk(n < lim, 1);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        apb(1, 1, $random(seed));
        apb(0, 1, 0);
        chk(r, 32'h0040);
        apb(0, 4, 0);
        chk(err, 1'b1);
        for (p = 0; p < 3; p++) begin
            apb(1, 0, 3);
            apb(1, 2, 32'h00c0 | (p << 2));
            apb(1, 3, 0);
            wait_for(0, 9000);
            t0 = $realtime;
            apb(1, 3, $random(seed));
            @(posedge pclk);
            chk(timer_irq, 1'b0);
            wait_for(0, 9000);
            n = int'(($realtime - t0) / 8);
            chk(n >= 24 * 16 ** p - 8 && n <= 32 * 16 ** p + 8, 1);
            apb(1, 3, 0);
        end
        apb(1, 2, 32'h01c0);
        apb(0, 1, 0);
        a = r;
        repeat (40) @(posedge pclk);
        apb(0, 1, 0);
        chk(r > a, 1);
        apb(1, 2, 32'h01c1);
        periph_powerdown <= 1;
        repeat (8) @(posedge pclk);
        apb(0, 1, 0);
        a = r;
        repeat (40) @(posedge pclk);
        apb(0, 1, 0);
        chk(r, a);
        periph_powerdown <= 0;
        apb(1, 2, 32'h01c4);
        apb(0, 1, 0);
        a = r;
        clk_en <= 0;
        repeat (400) @(posedge pclk);
        clk_en <= 1;
        apb(0, 1, 0);
        chk(r - a <= 1, 1);
        apb(1, 2, 32'h0080);
        wait_for(0, 2000);
        apb(0, 1, 0);
        chk(r >= 32'h0000fff0, 1);
        $display("test normal mode done");
        a = TMIN + ($random(seed) & 7);
        apb(1, 0, a);
        apb(1, 2, 32'h0022);
        repeat (6) begin
            apb(1, 3, $random(seed));
            repeat (1500 + ($random(seed) & 511)) @(posedge pclk);
        end
        chk(timer_irq, 1'b0);
        apb(0, 1, 0);
        chk(r <= a && r > 0, 1);
        apb(1, 2, $random(seed));
        apb(1, 0, $random(seed));
        apb(0, 2, 0);
        chk(r, 32'h0022);
        apb(0, 0, 0);
        chk(r, a);
        apb(1, 3, 0);
        debug_halt <= 1;
        repeat (8) @(posedge pclk);
        apb(0, 1, 0);
        a = r;
        repeat (40) @(posedge pclk);
        apb(0, 1, 0);
        chk(r, a);
        debug_halt <= 0;
        periph_powerdown <= 1;
        repeat (40) @(posedge pclk);
        apb(0, 1, 0);
        chk(r < a, 1);
        wait_for(0, 9000);
        chk(timer_irq, 1'b1);
        periph_powerdown <= 0;
        $display("test watchdog irq done");
        presetn <= 0;
        repeat (4) @(posedge pclk);
        presetn <= 1;
        apb(0, 2, 0);
        chk(r, 32'h0000);
        apb(1, 0, TMIN);
        apb(1, 2, 32'h0020);
        apb(1, 3, 0);
        wait_for(1, 9000);
        chk(n >= 8 * TMIN - 16 && n <= 8 * TMIN + 16, 1);
        chk(timer_irq, 1'b0);
        $display("test watchdog reset done");
        close_out();
    end
    initial begin
        #600us;
        failures++;
        close_out();
    end
endmodule
